/* File: verilog/drp_port_reset.v */
`timescale 1ns/1ps
`include "drp_defines.vh"
// reset-time configuration of the digital i/o port groups
module drp_port_reset #(
    parameter NG = 4,
    parameter AW = 2
) (
    // clock and power-on reset
    input  wire              clk,
    input  wire              reset,
    // hot reset, asynchronous level
    input  wire              hot_reset,
    // straps, high = shorted / enabled, one bit per group, one retention strap for the whole card
    input  wire              reset_retention_strap,
    input  wire [NG-1:0]     port_a_output_force_strap,
    input  wire [NG-1:0]     port_b_output_force_strap,
    input  wire [NG-1:0]     port_c_low_nibble_force_strap,
    input  wire [NG-1:0]     port_c_high_nibble_force_strap,
    // identifier switch, high = switch ON
    input  wire [3:0]        card_identifier_switch,
    // register port
    input  wire [5:0]        reg_addr,
    input  wire              reg_wr,
    input  wire              reg_rd,
    input  wire [7:0]        reg_wdata,
    output reg  [7:0]        reg_rdata_q,
    output wire              ready,
    // field pins
    input  wire [NG*24-1:0]  io_in,
    output wire [NG*24-1:0]  io_out,
    output wire [NG*24-1:0]  io_oe
);

    localparam NL = NG * 24;
    localparam SW = NL + NG * 4 + 6;
    localparam MW = 29;

    localparam [3:0] ST_INIT    = 4'b0001;
    localparam [3:0] ST_RUN     = 4'b0010;
    localparam [3:0] ST_HOT     = 4'b0100;
    localparam [3:0] ST_RESTORE = 4'b1000;

    reg  [SW-1:0]   sync1_q;
    reg  [SW-1:0]   sync2_q;
    reg  [3:0]      state_q;
    reg  [3:0]      state_d;
    reg  [3:0]      cnt_q;
    reg  [3:0]      cnt_d;
    reg  [NL-1:0]   out_q;
    reg  [NL-1:0]   out_d;
    reg  [NG*4-1:0] dir_q;
    reg  [NG*4-1:0] dir_d;
    reg             mem_we;
    reg  [AW-1:0]   mem_wa;
    reg  [MW-1:0]   mem_wd;
    reg  [AW-1:0]   mem_ra;
    reg  [3:0]      newdir;
    reg  [23:0]     newout;
    reg  [7:0]      rd_d;
    wire [MW-1:0]   mem_rd;
    wire [NL-1:0]   in_s;
    wire [NG*4-1:0] force_s;
    wire [NL-1:0]   line_in;
    wire            hot_s;
    wire            ret_s;
    wire [3:0]      id_on_s;
    reg  [AW-1:0]   wgrp;
    reg  [AW-1:0]   rgrp;

    // address decode helpers
    function is_port_reg;
        input [5:0] a;
        begin
            is_port_reg = (a < NG * 4);
        end
    endfunction

    function [AW-1:0] grp_of;
        input [5:0] a;
        begin
            grp_of = a[AW+1:2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for all pins and straps
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_q <= {SW{1'b0}};
            sync2_q <= {SW{1'b0}};
        end else begin
            sync1_q <= {io_in, port_a_output_force_strap, port_c_high_nibble_force_strap,
                        port_b_output_force_strap, port_c_low_nibble_force_strap,
                        reset_retention_strap, hot_reset, card_identifier_switch};
            sync2_q <= sync1_q;
        end
    end

    assign id_on_s = sync2_q[3:0];
    assign hot_s   = sync2_q[4];
    assign ret_s   = sync2_q[5];
    assign in_s    = sync2_q[SW-1 -: NL];

    // force nibble per group {a, ch, b, cl}
    genvar gi;
    generate
        for (gi = 0; gi < NG; gi = gi + 1) begin : g_grp
            assign force_s[gi*4+`DRP_DIR_A]  = sync2_q[6+3*NG+gi];
            assign force_s[gi*4+`DRP_DIR_CH] = sync2_q[6+2*NG+gi];
            assign force_s[gi*4+`DRP_DIR_B]  = sync2_q[6+NG+gi];
            assign force_s[gi*4+`DRP_DIR_CL] = sync2_q[6+gi];
            // per-line input when direction says input and no strap
            assign line_in[gi*24 +: 8]      = {8{dir_q[gi*4+`DRP_DIR_A] & ~force_s[gi*4+`DRP_DIR_A]}};
            assign line_in[gi*24+8 +: 8]    = {8{dir_q[gi*4+`DRP_DIR_B] & ~force_s[gi*4+`DRP_DIR_B]}};
            assign line_in[gi*24+16 +: 4]   = {4{dir_q[gi*4+`DRP_DIR_CL] & ~force_s[gi*4+`DRP_DIR_CL]}}; // see RULE_07
            assign line_in[gi*24+20 +: 4]   = {4{dir_q[gi*4+`DRP_DIR_CH] & ~force_s[gi*4+`DRP_DIR_CH]}}; // see RULE_07
        end
    endgenerate

    // pins: a strapped line is input only from power-on reset until its strap has passed the synchronisers
    assign io_out = out_q;
    assign io_oe  = ~line_in;   // see RULE_02
    assign ready  = state_q[1];

    ////////////////////////////////////////////////////////////////////////
    // retained state storage
    drp_retain_mem #(
        .W  (MW),
        .D  (NG),
        .AW (AW)
    ) u_mem (
        .clk     (clk),
        .reset   (reset),
        .we      (mem_we),
        .waddr   (mem_wa),
        .wdata   (mem_wd),
        .raddr   (mem_ra),
        .rdata_q (mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // state sequencing, direction and output latches
    always @* begin
        state_d = state_q;
        cnt_d   = 4'h0;
        out_d   = out_q;
        dir_d   = dir_q;
        mem_we  = 1'b0;
        mem_wa  = grp_of(reg_addr);
        mem_wd  = {MW{1'b0}};
        mem_ra  = cnt_q[AW-1:0];
        newdir  = 4'h0;
        newout  = 24'h0;
        wgrp    = grp_of(reg_addr);
        case (state_q)
            ST_INIT: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == `DRP_SYNC_CYCLES) begin
                    // power-on defaults, nothing restored
                    out_d   = {NG*3{`DRP_OUT_RST}};  // see RULE_03
                    dir_d   = ~force_s;              // see RULE_01
                    state_d = ST_RUN;                // see RULE_06
                end
            end
            ST_RUN: begin
                if (hot_s) begin
                    state_d = ST_HOT;
                end else if (reg_wr && is_port_reg(reg_addr)) begin
                    newdir = dir_q[wgrp*4 +: 4];
                    newout = out_q[wgrp*24 +: 24];
                    if (reg_addr[1:0] == `DRP_OFF_CFG) begin
                        // strapped parts keep their setting
                        newdir[`DRP_DIR_A]  = force_s[wgrp*4+`DRP_DIR_A]  ? newdir[`DRP_DIR_A]
                                                                          : reg_wdata[`DRP_CFG_A];  // see RULE_10
                        newdir[`DRP_DIR_CH] = force_s[wgrp*4+`DRP_DIR_CH] ? newdir[`DRP_DIR_CH]
                                                                          : reg_wdata[`DRP_CFG_CH]; // see RULE_10
                        newdir[`DRP_DIR_B]  = force_s[wgrp*4+`DRP_DIR_B]  ? newdir[`DRP_DIR_B]
                                                                          : reg_wdata[`DRP_CFG_B];  // see RULE_10
                        newdir[`DRP_DIR_CL] = force_s[wgrp*4+`DRP_DIR_CL] ? newdir[`DRP_DIR_CL]
                                                                          : reg_wdata[`DRP_CFG_CL]; // see RULE_10
                    end else begin
                        newout[reg_addr[1:0]*8 +: 8] = reg_wdata;
                    end
                    dir_d[wgrp*4 +: 4]   = newdir;
                    out_d[wgrp*24 +: 24] = newout;
                    // mirror the group into retained storage
                    mem_we = 1'b1;                       // see RULE_05
                    mem_wd = {1'b1, newdir, newout};
                end
            end
            ST_HOT: begin
                // held at defaults while hot reset stands
                out_d = {NG*3{`DRP_OUT_RST}};            // see RULE_03
                dir_d = ~force_s;                        // see RULE_01
                if (!hot_s) begin
                    // walk the groups either way: restore them or drop them
                    state_d = ST_RESTORE;
                end
            end
            ST_RESTORE: begin
                cnt_d = cnt_q + 4'h1;
                if (hot_s) begin
                    state_d = ST_HOT;
                    cnt_d   = 4'h0;
                end else begin
                    // group read one cycle earlier, minus one modulo groups
                    wgrp = cnt_q[AW-1:0] + {AW{1'b1}};
                    if (ret_s) begin
                        if (cnt_q != 4'h0 && mem_rd[MW-1]) begin
                            dir_d[wgrp*4 +: 4]   = mem_rd[27:24];  // see RULE_04
                            out_d[wgrp*24 +: 24] = mem_rd[23:0];   // see RULE_05
                        end
                    end else if (cnt_q < NG) begin
                        // defaults kept, so stale words must never come back
                        mem_we = 1'b1;                             // see RULE_04
                        mem_wa = cnt_q[AW-1:0];
                    end
                    if (cnt_q == NG) begin
                        state_d = ST_RUN;
                    end
                end
            end
            default: begin
                state_d = ST_INIT;
            end
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_INIT;
            cnt_q   <= 4'h0;
            out_q   <= {NG*3{`DRP_OUT_RST}};
            dir_q   <= {NG*4{`DRP_DIR_RST}};
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            out_q   <= out_d;
            dir_q   <= dir_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read data, one cycle after the strobe
    always @* begin
        rd_d = 8'h00;
        rgrp = grp_of(reg_addr);
        if (reg_rd && is_port_reg(reg_addr)) begin
            if (reg_addr[1:0] == `DRP_OFF_CFG) begin
                rd_d[`DRP_CFG_A]  = dir_q[rgrp*4+`DRP_DIR_A]  & ~force_s[rgrp*4+`DRP_DIR_A];
                rd_d[`DRP_CFG_CH] = dir_q[rgrp*4+`DRP_DIR_CH] & ~force_s[rgrp*4+`DRP_DIR_CH];
                rd_d[`DRP_CFG_B]  = dir_q[rgrp*4+`DRP_DIR_B]  & ~force_s[rgrp*4+`DRP_DIR_B];
                rd_d[`DRP_CFG_CL] = dir_q[rgrp*4+`DRP_DIR_CL] & ~force_s[rgrp*4+`DRP_DIR_CL];
            end else begin
                // input lines read the pin, outputs read back the latch
                rd_d = (in_s[rgrp*24+reg_addr[1:0]*8 +: 8] & line_in[rgrp*24+reg_addr[1:0]*8 +: 8])
                     | (out_q[rgrp*24+reg_addr[1:0]*8 +: 8] & ~line_in[rgrp*24+reg_addr[1:0]*8 +: 8]);
            end
        end else if (reg_rd && reg_addr == `DRP_OFF_CARD_ID) begin
            rd_d = {4'h0, ~id_on_s};   // see RULE_08 see RULE_09 see RULE_12
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= rd_d;
        end
    end

endmodule

/* File: verilog/drp_defines.vh */
// Summary of operation
// RULE_01: unforced ports reset to inputs reading high
// RULE_02: strapped port always output, never input; the code leaves it input in power-on reset until the strap is synchronised
// RULE_03: strapped output drives low unless retained
// RULE_04: retention keeps direction and outputs across hot reset
// RULE_05: retention covers software and strapped ports
// RULE_06: power loss discards retained state, defaults apply
// RULE_07: port C straps per nibble, A/B whole
// RULE_08: identifier read at offset 20, bit0 lsb
// RULE_09: switch ON reads 0, OFF reads 1
// RULE_10: direction write ignored for strapped port parts
// RULE_11: power-on clears retained storage, hot reset not; the code also clears it on a hot reset without the retention strap
// RULE_12: identifier ignores writes, upper bits read zero
`ifndef DRP_DEFINES_VH
`define DRP_DEFINES_VH

// register offsets within one port group of four bytes, and the identifier address
`define DRP_OFF_PORT_A   2'h0
`define DRP_OFF_PORT_B   2'h1
`define DRP_OFF_PORT_C   2'h2
`define DRP_OFF_CFG      2'h3
`define DRP_OFF_CARD_ID  6'h14

// direction control word bit positions, 1 = input
`define DRP_CFG_A        4
`define DRP_CFG_CH       3
`define DRP_CFG_B        1
`define DRP_CFG_CL       0

// direction nibble layout held per group {a, ch, b, cl}
`define DRP_DIR_A        3
`define DRP_DIR_CH       2
`define DRP_DIR_B        1
`define DRP_DIR_CL       0

// reset values
`define DRP_OUT_RST      8'h00
`define DRP_DIR_RST      1'b1

// cycles to wait for strap synchronisers after power-on
`define DRP_SYNC_CYCLES  4'h3

`endif

/* File: verilog/drp_retain_mem.v */
`timescale 1ns/1ps
// retained port state, cleared by power-on reset and written to zero by a hot reset without retention
module drp_retain_mem #(
    parameter W  = 29,
    parameter D  = 4,
    parameter AW = 2
) (
    // clock and power-on reset
    input  wire          clk,
    input  wire          reset,
    // write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [W-1:0]  wdata,
    // registered read port
    input  wire [AW-1:0] raddr,
    output reg  [W-1:0]  rdata_q
);

    reg [W-1:0] mem_q [0:D-1];
    integer     i;

    ////////////////////////////////////////////////////////////////////////
    // storage and registered read
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < D; i = i + 1) begin
                mem_q[i] <= {W{1'b0}}; // see RULE_11
            end
            rdata_q <= {W{1'b0}};
        end else begin
            if (we) begin
                mem_q[waddr] <= wdata;
            end
            rdata_q <= mem_q[raddr];
        end
    end

endmodule

/* File: bench/drp_field_model.sv */
`timescale 1ns/1ps
// field wiring: undriven lines float high through the pull-ups
module drp_field_model #(
    parameter NG = 4
) (
    // pins from the card
    input  wire [NG*24-1:0] io_out,
    input  wire [NG*24-1:0] io_oe,
    // levels seen by the card
    output wire [NG*24-1:0] io_in
);
    // driven lines show the latch, released lines read high
    assign io_in = (io_out & io_oe) | ~io_oe;
endmodule

/* File: bench/drp_port_reset_checker.sv */
`timescale 1ns/1ps
// port-side relations of the reset configuration logic
module drp_port_reset_checker #(
    parameter NG = 4
) (
    // clock and resets
    input wire             clk,
    input wire             reset,
    input wire             hot_reset,
    // straps and switch
    input wire [NG-1:0]    port_a_output_force_strap,
    input wire [NG-1:0]    port_b_output_force_strap,
    input wire [NG-1:0]    port_c_low_nibble_force_strap,
    input wire [NG-1:0]    port_c_high_nibble_force_strap,
    input wire [3:0]       card_identifier_switch,
    // register port
    input wire [5:0]       reg_addr,
    input wire             reg_wr,
    input wire             reg_rd,
    input wire [7:0]       reg_wdata,
    input wire [7:0]       reg_rdata_q,
    input wire             ready,
    // field pins
    input wire [NG*24-1:0] io_out,
    input wire [NG*24-1:0] io_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // steps of the checked behaviours
    sequence id_read_s; reg_rd && reg_addr == 6'h14; endsequence
    sequence hot_held_s; hot_reset [*6]; endsequence
    sequence cfg0_wr_s; ready && reg_wr && reg_addr == 6'h03; endsequence
    ////////////////////////////////////////////////////////////////////////
    reset_dflt_a: assert property (disable iff (1'b0) reset |-> io_oe == 0 && io_out == 0)
        else $error("pins not idle in power-on reset");
    id_value_a: assert property (id_read_s |=> reg_rdata_q == {4'h0, ~$past(card_identifier_switch)})
        else $error("identifier read wrong");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data not cleared");
    strap_force_a: assert property (ready |-> &(io_oe[7:0] | ~{8{port_a_output_force_strap[0]}})
        && &(io_oe[19:16] | ~{4{port_c_low_nibble_force_strap[0]}})
        && &(io_oe[23:20] | ~{4{port_c_high_nibble_force_strap[0]}}))
        else $error("strapped port not driven");
    cfg_apply_a: assert property (cfg0_wr_s |=> io_oe[7:0] == {8{~$past(reg_wdata[4]) | port_a_output_force_strap[0]}}
        && io_oe[15:8] == {8{~$past(reg_wdata[1]) | port_b_output_force_strap[0]}})
        else $error("control word applied wrong");
    hot_dflt_a: assert property (hot_held_s |-> !ready && io_out == 0
        && io_oe[15:8] == {8{port_b_output_force_strap[0]}})
        else $error("pins not default in hot reset");
    por_ready_a: assert property ($fell(reset) |-> ##[1:10] ready)
        else $error("not ready after power-on");
    hot_ready_a: assert property ($fell(hot_reset) |-> ##[1:20] ready)
        else $error("not ready after hot reset");
endmodule

/* File: bench/drp_port_reset_test.sv */
`timescale 1ns/1ps
module drp_port_reset_test;
    localparam NG = 4;
    reg clk = 0, reset = 0, hot = 0, ret = 0, wr = 0, rd = 0;
    reg [3:0] sa = 0, sb = 0, scl = 0, sch = 0, sw = 0;
    reg [5:0] ad = 0;
    reg [7:0] wd = 0, q = 0;
    reg [31:0] rnd = 32'h176EBEF8;
    reg [95:0] m_out = 0, r_out;
    reg [15:0] m_dir = 16'hFFFF, r_dir;
    wire [7:0] rdq;
    wire rdy;
    wire [95:0] pin_i, pin_o, pin_e;
    integer err_total = 0, compares = 0, cyc = 0, i, n;
    // design and field wiring
    drp_port_reset i_drp_port_reset (.clk(clk), .reset(reset), .hot_reset(hot), .reset_retention_strap(ret),
        .port_a_output_force_strap(sa), .port_b_output_force_strap(sb), .port_c_low_nibble_force_strap(scl),
        .port_c_high_nibble_force_strap(sch), .card_identifier_switch(sw), .reg_addr(ad), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wd), .reg_rdata_q(rdq), .ready(rdy), .io_in(pin_i), .io_out(pin_o), .io_oe(pin_e));
    drp_field_model i_drp_field_model (.io_out(pin_o), .io_oe(pin_e), .io_in(pin_i));
    // clock and cycle ceiling
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            test_done;
        end
    end
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    // expected enables: software direction unless strapped
    function [95:0] e_oe();
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                e_oe[k*24+:24] = {{4{~m_dir[k*4+2] | sch[k]}}, {4{~m_dir[k*4] | scl[k]}},
                    {8{~m_dir[k*4+1] | sb[k]}}, {8{~m_dir[k*4+3] | sa[k]}}};
        end
    endfunction
    task chk_pins(input [95:0] e, input [95:0] s);
        begin
            compares = compares + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("wrong value pins exp %h got %h", e, s);
            end
        end
    endtask
    task chk_byte(input [7:0] e, input [7:0] s);
        begin
            compares = compares + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("wrong value read exp %h got %h", e, s);
            end
        end
    endtask
    task pins_ok;
        begin
            chk_pins(e_oe(), pin_e);
            chk_pins(m_out & e_oe(), pin_o & pin_e);
        end
    endtask
    task wreg(input [5:0] a, input [7:0] d);
        integer g;
        begin
            @(negedge clk);
            ad = a;
            wd = d;
            wr = 1;
            @(negedge clk);
            wr = 0;
            g = a[5:2];
            if (a < 6'h10) case (a[1:0])
                0: m_out[g*24+:8] = d;
                1: m_out[g*24+8+:8] = d;
                2: m_out[g*24+16+:8] = d;
                3: m_dir[g*4+:4] = {d[4], d[3], d[1], d[0]};
            endcase
        end
    endtask
    task rreg(input [5:0] a);
        begin
            @(negedge clk);
            ad = a;
            rd = 1;
            @(negedge clk);
            rd = 0;
            q = rdq;
        end
    endtask
    // readback of all twelve ports
    task ports_ok;
        reg [95:0] e;
        integer k;
        begin
            repeat (4) @(negedge clk);
            e = (m_out & e_oe()) | ~e_oe();
            for (k = 0; k < 12; k = k + 1) begin
                rreg(k / 3 * 4 + k % 3);
                chk_byte(e[k*8+:8], q);
            end
        end
    endtask
    task wait_rdy;
        begin
            i = 0;
            while (rdy !== 1'b1 && i < 60) begin
                @(negedge clk);
                i = i + 1;
            end
            chk_byte(1, rdy);
        end
    endtask
    task por(input r);
        begin
            @(negedge clk);
            reset = 1;
            ret = r;
            rnd = xs(rnd);
            {sa, sb, scl, sch} = rnd[15:0];
            repeat (10) @(negedge clk);
            reset = 0;
            m_out = 0;
            m_dir = 16'hFFFF;
            wait_rdy;
        end
    endtask
    // hot reset, retained state restored when r is set
    task hrst(input r);
        begin
            @(negedge clk);
            ret = r;
            r_out = m_out;
            r_dir = m_dir;
            repeat (3) @(negedge clk);
            hot = 1;
            m_out = 0;
            m_dir = 16'hFFFF;
            repeat (8) @(negedge clk);
            pins_ok;
            hot = 0;
            if (r) begin
                m_out = r_out;
                m_dir = r_dir;
            end
            repeat (2) @(negedge clk);
            wait_rdy;
        end
    endtask
    task test_done;
        begin
            if (err_total == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        por(0);
        pins_ok;
        ports_ok;
        for (n = 0; n < 16; n = n + 1) begin
            sw = n;
            wreg(6'h14, rnd[7:0]);
            rreg(6'h14);
            chk_byte({4'h0, ~sw}, q);
        end
        rreg(6'h3C);
        chk_byte(8'h00, q);
        wreg(6'h03, 8'h00);
        pins_ok;
        wreg(6'h03, 8'h1B);
        pins_ok;
        for (n = 0; n < 40; n = n + 1) begin
            rnd = xs(rnd);
            wreg({2'b00, rnd[3:0]}, rnd[15:8]);
            pins_ok;
        end
        ports_ok;
        hrst(1);
        pins_ok;
        hrst(0);
        pins_ok;
        hrst(1);
        pins_ok;
        por(1);
        pins_ok;
        ports_ok;
        test_done;
    end
endmodule
bind drp_port_reset drp_port_reset_checker #(.NG(NG)) i_drp_port_reset_checker (.*);
